/* core/cbta_pkg.sv */
/*
  Constants and types for the control byte and over-temperature alarm block.
  Assumes a single 100 MHz clock; sclk, din, rd_wr and convert_start_n are synchronised inside the core.
*/
`default_nettype none
package cbta_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_CONV_TEMP_NS = 27000;
  localparam int T_CONV_INPUT_NS = 9000;
  localparam int CONV_TEMP_CYCLES = (T_CONV_TEMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_INPUT_CYCLES = (T_CONV_INPUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CNT_W = 12;

  localparam int CTRL_BYTE_W = 8;
  localparam int CHAN_W = 3;
  localparam int RESULT_W = 10;
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] WRITE_BITS = 4'h8;
  localparam logic [BIT_CNT_W-1:0] READ_BITS = 4'ha;

  localparam logic [CHAN_W-1:0] CHAN_TEMP = 3'h0;
  localparam logic [CHAN_W-1:0] CHAN_IN1 = 3'h1;
  localparam logic [CHAN_W-1:0] CHAN_IN2 = 3'h2;
  localparam logic [CHAN_W-1:0] CHAN_IN3 = 3'h3;
  localparam logic [CHAN_W-1:0] CHAN_IN4 = 3'h4;
  localparam logic [CHAN_W-1:0] CHAN_RSVD_A = 3'h5;
  localparam logic [CHAN_W-1:0] CHAN_RSVD_B = 3'h6;
  localparam logic [CHAN_W-1:0] CHAN_BANDGAP = 3'h7;

  localparam logic [CHAN_W-1:0] CHAN_RESET = 3'h0;
  localparam logic [CTRL_BYTE_W-1:0] THRESH_RESET = 8'h99;
  localparam int THRESH_OFFSET_DEG = 103;

  typedef struct packed {
    logic [4:0] upper;
    logic [CHAN_W-1:0] chan;
  } cbta_ctrl_byte_type;

  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_RUN = 2'b01,
    CONV_END = 2'b11
  } cbta_conv_state_type;
endpackage
`default_nettype wire

/* core/cbta_core.sv */
/*
  Control byte decoder, channel select, alarm threshold and over-temperature
  alarm with a conversion timer and a three-wire serial port.
  Assumes a controller drives sclk, din, rd_wr and convert_start_n
  asynchronously, and an analog front end presents the result on
  adc_result (clock domain) by the last cycle of each conversion, when it is captured.
*/
`default_nettype none
// Overview of operation
// R1: A written byte whose upper five bits are zero loads its low three bits into channel select.
// R2: Channel select is three bits and picks the input for the next conversion.
// R3: Codes 0 temp sensor, 1..4 inputs 1..4, 7 bandgap reference near midscale.
// R4: After reset channel select is zero, the temperature sensor.
// R5: A written byte with any upper five bit set is stored whole as the alarm threshold.
// R6: After a temperature conversion, result bits 9..2 above the threshold drive the alarm low.
// R7: The threshold equals alarm degrees plus 103 at one degree per step.
// R8: The alarm returns high when a serial read completes.
// R9: The alarm returns high when a later temperature result is not above the threshold.
// R10: After reset the threshold is 153, an alarm at 50 degrees.
// R11: The controller waits the acquisition time after a conversion or channel change.
// R12: A read completes on the rising edge of rd_wr.
// R13: Data enters on rising sclk edges and leaves on falling sclk edges.
// R14: The controller holds rd_wr high to read and low to write.
// R15: A falling edge of convert_start_n starts a conversion on the selected channel.
// R16: Conversions on other channels leave the alarm unchanged.
// R17: Codes 5 and 6 are reserved and are not loaded into channel select.
module cbta_core
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic din,
  input wire logic rd_wr,
  input wire logic convert_start_n,
  input wire logic [cbta_pkg::RESULT_W-1:0] adc_result,
  output logic dout,
  output logic dout_oe_n,
  output logic busy,
  output logic [cbta_pkg::CHAN_W-1:0] channel_select,
  output logic [cbta_pkg::CTRL_BYTE_W-1:0] alarm_threshold,
  output logic [cbta_pkg::RESULT_W-1:0] conv_result,
  output logic over_temp_alarm_n
);

  // Two-stage synchronisers; stage one is read only by stage two
  logic [1:0] sclk_meta;
  logic [1:0] din_meta;
  logic [1:0] rdwr_meta;
  logic [1:0] conv_meta;
  logic sclk_s;
  logic din_s;
  logic rdwr_s;
  logic conv_s;
  logic sclk_d;
  logic rdwr_d;
  logic conv_d;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      // Idle levels, so release of reset makes no false edge
      sclk_meta <= 2'h3;
      din_meta <= 2'h0;
      rdwr_meta <= 2'h0;
      conv_meta <= 2'h3;
    end
    else
    begin
      sclk_meta <= {sclk_meta[0], sclk};
      din_meta <= {din_meta[0], din};
      rdwr_meta <= {rdwr_meta[0], rd_wr};
      conv_meta <= {conv_meta[0], convert_start_n};
    end
  end

  assign sclk_s = sclk_meta[1];
  assign din_s = din_meta[1];
  assign rdwr_s = rdwr_meta[1];
  assign conv_s = conv_meta[1];

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      sclk_d <= 1'b1;
      rdwr_d <= 1'b0;
      conv_d <= 1'b1;
    end
    else
    begin
      sclk_d <= sclk_s;
      rdwr_d <= rdwr_s;
      conv_d <= conv_s;
    end
  end

  // Edge events, all one-cycle pulses
  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;
  // Rising rd_wr latches the result, so the alarm is released there
  wire read_start = rdwr_s & ~rdwr_d; // R12
  wire conv_fall = ~conv_s & conv_d;

  // Write path: shift on rising sclk while rd_wr is low
  logic [cbta_pkg::CTRL_BYTE_W-1:0] wr_shift;
  logic [cbta_pkg::BIT_CNT_W-1:0] wr_count;
  wire wr_shift_en = ~rdwr_s & sclk_rise; // R13 R14
  wire [cbta_pkg::CTRL_BYTE_W-1:0] next_wr_shift = {wr_shift[cbta_pkg::CTRL_BYTE_W-2:0], din_s};
  wire wr_byte_done = wr_shift_en && (wr_count == cbta_pkg::WRITE_BITS - 4'h1);
  cbta_pkg::cbta_ctrl_byte_type ctrl_byte;
  assign ctrl_byte = next_wr_shift;
  wire is_addr_byte = (ctrl_byte.upper == 5'h00); // R1
  wire chan_reserved = (ctrl_byte.chan == cbta_pkg::CHAN_RSVD_A) ||
                       (ctrl_byte.chan == cbta_pkg::CHAN_RSVD_B); // R17
  wire load_chan = wr_byte_done && is_addr_byte && !chan_reserved; // R1 R17
  wire load_thresh = wr_byte_done && !is_addr_byte; // R5

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_shift <= '0;
      wr_count <= '0;
    end
    else if (rdwr_s)
    begin
      wr_count <= '0;
    end
    else if (wr_shift_en)
    begin
      wr_shift <= next_wr_shift;
      wr_count <= wr_byte_done ? '0 : wr_count + 4'h1;
    end
  end

  // Registers; channel select steers the front end mux
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      channel_select <= cbta_pkg::CHAN_RESET; // R4
    end
    else if (load_chan)
    begin
      channel_select <= ctrl_byte.chan; // R1 R2 R3
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      alarm_threshold <= cbta_pkg::THRESH_RESET; // R10
    end
    else if (load_thresh)
    begin
      alarm_threshold <= next_wr_shift; // R5 R7
    end
  end

  // Conversion timer; the analog side is outside this core
  cbta_pkg::cbta_conv_state_type conv_state;
  cbta_pkg::cbta_conv_state_type next_conv_state;
  logic [cbta_pkg::CONV_CNT_W-1:0] conv_count;
  logic [cbta_pkg::CHAN_W-1:0] conv_chan;
  wire conv_is_temp = (channel_select == cbta_pkg::CHAN_TEMP);
  wire [cbta_pkg::CONV_CNT_W-1:0] conv_len = conv_is_temp ?
    cbta_pkg::CONV_CNT_W'(cbta_pkg::CONV_TEMP_CYCLES - 1) :
    cbta_pkg::CONV_CNT_W'(cbta_pkg::CONV_INPUT_CYCLES - 1);
  // A start during a conversion is ignored: the hold capacitor is busy
  wire conv_go = conv_fall && (conv_state == cbta_pkg::CONV_IDLE); // R15
  wire conv_last = (conv_state == cbta_pkg::CONV_RUN) && (conv_count == '0);
  wire end_temp = (conv_state == cbta_pkg::CONV_END) && (conv_chan == cbta_pkg::CHAN_TEMP); // R16

  always_comb
  begin
    case (conv_state)
      cbta_pkg::CONV_IDLE: next_conv_state = conv_go ? cbta_pkg::CONV_RUN : cbta_pkg::CONV_IDLE;
      cbta_pkg::CONV_RUN: next_conv_state = conv_last ? cbta_pkg::CONV_END : cbta_pkg::CONV_RUN;
      cbta_pkg::CONV_END: next_conv_state = cbta_pkg::CONV_IDLE;
      default: next_conv_state = cbta_pkg::CONV_IDLE;
    endcase
  end

  // Count loads at start and runs down to zero in RUN
  wire [cbta_pkg::CONV_CNT_W-1:0] next_conv_count = conv_go ? conv_len :
    (conv_state == cbta_pkg::CONV_RUN) ? conv_count - 12'h001 :
    conv_count;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      conv_state <= cbta_pkg::CONV_IDLE;
      conv_count <= '0;
    end
    else
    begin
      conv_state <= next_conv_state;
      conv_count <= next_conv_count;
    end
  end

  // Channel latched, so a write mid-conversion cannot alter it
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      conv_chan <= cbta_pkg::CHAN_RESET;
    end
    else if (conv_go)
    begin
      conv_chan <= channel_select; // R2 R15
    end
  end

  // Start and last cycle lie in different states, never together
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      busy <= 1'b0;
    end
    else if (conv_go)
    begin
      busy <= 1'b1; // R15
    end
    else if (conv_last)
    begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      conv_result <= '0;
    end
    else if (conv_last)
    begin
      conv_result <= adc_result;
    end
  end

  // Alarm compare uses the eight upper result bits against threshold
  wire over_limit = conv_result[cbta_pkg::RESULT_W-1:2] > alarm_threshold; // R6 R7
  wire alarm_set = end_temp && over_limit; // R6
  wire alarm_clear = (end_temp && !over_limit) || read_start; // R8 R9 R12

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      over_temp_alarm_n <= 1'b1;
    end
    else if (alarm_set)
    begin
      // A new alarm beats a read finishing in the same cycle
      over_temp_alarm_n <= 1'b0; // R6
    end
    else if (alarm_clear)
    begin
      over_temp_alarm_n <= 1'b1; // R8 R9
    end
  end

  // Read path: result MSB first, next bit on each falling sclk
  logic [cbta_pkg::RESULT_W-1:0] rd_shift;
  wire rd_shift_en = rdwr_s && sclk_fall; // R13 R14

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_shift <= '0;
      dout <= 1'b0;
    end
    else if (read_start)
    begin
      rd_shift <= {conv_result[cbta_pkg::RESULT_W-2:0], 1'b0};
      dout <= conv_result[cbta_pkg::RESULT_W-1];
    end
    else if (rd_shift_en)
    begin
      dout <= rd_shift[cbta_pkg::RESULT_W-1]; // R13
      rd_shift <= {rd_shift[cbta_pkg::RESULT_W-2:0], 1'b0};
    end
  end

  // Driver released as soon as rd_wr falls, before sclk can move
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      dout_oe_n <= 1'b1;
    end
    else if (read_start)
    begin
      dout_oe_n <= 1'b0; // R14
    end
    else if (!rdwr_s)
    begin
      dout_oe_n <= 1'b1;
    end
  end

endmodule
`default_nettype wire

/* test/cbta_core_assertions.sv */
/* Port checker for cbta_core.
   Assumes one clock domain and the bind at the foot. */
`default_nettype none
module cbta_core_assertions
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic rd_wr,
  input wire logic convert_start_n,
  input wire logic dout_oe_n,
  input wire logic busy,
  input wire logic [2:0] channel_select,
  input wire logic [7:0] alarm_threshold,
  input wire logic [9:0] conv_result,
  input wire logic over_temp_alarm_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  logic [11:0] cnt;
  logic [2:0] chan_lat;
  // Channel taken while idle, as it is latched at start
  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
    begin
      cnt <= 12'h000;
      chan_lat <= 3'h0;
    end
    else
    begin
      cnt <= busy ? cnt + 12'h001 : 12'h000;
      chan_lat <= busy ? chan_lat : channel_select;
    end
  property p_start; $fell(convert_start_n) && !busy |-> ##[1:8] busy; endproperty
  a_start: assert property (p_start) else $error("start lost");
  // Busy high 2700 samples for temperature, 900 otherwise
  property p_len; $fell(busy) |-> cnt == (chan_lat == 3'h0 ? 12'ha8c : 12'h384); endproperty
  a_len: assert property (p_len) else $error("bad length");
  property p_alarm; $fell(busy) && chan_lat == 3'h0 |=> over_temp_alarm_n == !(conv_result[9:2] > alarm_threshold); endproperty
  a_alarm: assert property (p_alarm) else $error("bad alarm");
  property p_keep; $fell(busy) && chan_lat != 3'h0 |=> $stable(over_temp_alarm_n); endproperty
  a_keep: assert property (p_keep) else $error("alarm moved");
  property p_clear; $rose(rd_wr) |-> ##[1:6] over_temp_alarm_n; endproperty
  a_clear: assert property (p_clear) else $error("no clear");
  property p_oe; rd_wr [*6] |-> !dout_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("no drive");
  property p_thr; $changed(alarm_threshold) |-> alarm_threshold[7:3] != 5'h00; endproperty
  a_thr: assert property (p_thr) else $error("bad threshold");
  property p_chan; $changed(channel_select) |-> channel_select != 3'h5 && channel_select != 3'h6; endproperty
  a_chan: assert property (p_chan) else $error("bad channel");
  c_temp: cover property ($fell(busy) && chan_lat == 3'h0);
  c_other: cover property ($fell(busy) && chan_lat != 3'h0);
  c_read: cover property ($fell(rd_wr));
endmodule
bind cbta_core cbta_core_assertions cbta_core_assertions_i (.clock, .resetn, .rd_wr, .convert_start_n,
  .dout_oe_n, .busy, .channel_select, .alarm_threshold, .conv_result, .over_temp_alarm_n);
`default_nettype wire

/* test/cbta_host.sv */
/* Controller model for the serial port and convert start.
   Assumes calls begin on a falling clock edge. */
`default_nettype none
module cbta_host
(
  output var logic sclk,
  output var logic din,
  output var logic rd_wr,
  output var logic convert_start_n,
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 1ps;
  // Serial clock idles high, still between frames
  initial
  begin
    sclk = 1'b1;
    din = 1'b0;
    rd_wr = 1'b0;
    convert_start_n = 1'b1;
  end
  task automatic wr(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      sclk = 1'b0;
      din = b[i];
      #80 sclk = 1'b1;
      #80;
    end
    // No pull on the line, so never leave the last bit
    din = ~din;
  endtask
  task automatic rd(output logic [9:0] d);
    rd_wr = 1'b1;
    #80 d[9] = dout;
    for (int i = 8; i >= 0; i--)
    begin
      sclk = 1'b0;
      #80 d[i] = dout;
      sclk = 1'b1;
      #80;
    end
    rd_wr = 1'b0;
    #80;
  endtask
  task automatic conv();
    #400 convert_start_n = 1'b0;
    #80 convert_start_n = 1'b1;
  endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
/* Self-checking bench for cbta_core.
   Assumes the checker binds itself from its own file. */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [9:0] adc_result = 10'h000;
  logic sclk, din, rd_wr, convert_start_n, dout, dout_oe_n, busy, over_temp_alarm_n;
  logic [2:0] channel_select;
  logic [7:0] alarm_threshold;
  logic [9:0] conv_result, d;
  int fails = 0, checks = 0;
  logic [31:0] seed = 32'h0000004a;
  logic [7:0] thr = 8'h99;
  logic [2:0] chan = 3'h0;
  logic alarm = 1'b1;
  logic [9:0] res = 10'h000;
  always #5 clock = ~clock;
  cbta_core cbta_core_i (.clock, .resetn, .sclk, .din, .rd_wr, .convert_start_n, .adc_result, .dout,
    .dout_oe_n, .busy, .channel_select, .alarm_threshold, .conv_result, .over_temp_alarm_n);
  cbta_host host_i (.sclk, .din, .rd_wr, .convert_start_n, .dout);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] b);
    host_i.wr(b);
    repeat (6) @(negedge clock);
    if (b[7:3] != 5'h00)
      thr = b;
    else if (b[2:0] != 3'h5 && b[2:0] != 3'h6)
      chan = b[2:0];
    chk(channel_select, chan);
    chk(alarm_threshold, thr);
  endtask
  // Result sits delta steps above the threshold
  task automatic cv(input logic [7:0] delta);
    int n;
    seed = xs(seed);
    adc_result = {thr + delta, seed[1:0]};
    res = adc_result;
    host_i.conv();
    chk(busy, 1'b1);
    for (n = 0; n < 4000 && busy !== 1'b0; n++)
      @(negedge clock);
    if (n == 4000)
    begin
      fails++;
      summarize();
    end
    repeat (2) @(negedge clock);
    if (chan == 3'h0)
      alarm = adc_result[9:2] > thr ? 1'b0 : 1'b1;
    chk(conv_result, res);
    chk(over_temp_alarm_n, alarm);
  endtask
  // Alarm must already be high while rd_wr is still up
  task automatic rd();
    alarm = 1'b1;
    fork
      host_i.rd(d);
      begin
        repeat (8) @(negedge clock);
        chk(over_temp_alarm_n, alarm);
        chk(dout_oe_n, 1'b0);
      end
    join
    chk(d, res);
    chk(over_temp_alarm_n, alarm);
    chk(dout_oe_n, 1'b1);
  endtask
  initial
  begin
    repeat (20) @(negedge clock);
    resetn = 1'b1;
    chk(channel_select, 3'h0);
    chk(alarm_threshold, 8'h99);
    chk(over_temp_alarm_n, 1'b1);
    for (int c = 7; c >= 0; c--)
      wr(c[7:0]);
    cv(8'h01);
    rd();
    cv(8'h05);
    cv(8'h00);
    cv(8'h01);
    wr(8'h01);
    cv(8'hf0);
    rd();
    wr(8'ha3);
    wr(8'h00);
    for (int k = 0; k < 4; k++)
    begin
      seed = xs(seed);
      wr(seed[7:0] | 8'h08);
      cv(seed[15:8]);
    end
    // Second reset in mid-run; sclk idles high across it
    resetn = 1'b0;
    repeat (3) @(negedge clock);
    resetn = 1'b1;
    thr = 8'h99;
    chan = 3'h0;
    alarm = 1'b1;
    res = 10'h000;
    chk(channel_select, chan);
    chk(alarm_threshold, thr);
    chk(over_temp_alarm_n, alarm);
    cv(8'h02);
    rd();
    wr(8'h07);
    summarize();
  end
endmodule
`default_nettype wire
